// ---- error_history_stack.sv ----
`timescale 1ns/1ns
`default_nettype none
`include "error_history_stack_params.svh"

module error_history_stack #(
    parameter int ADDR_W = 6
) (
    input  wire logic                                  clk,
    input  wire logic                                  sys_rst,
    input  wire error_history_stack_pkg::fault_report_t faultIn,
    input  wire logic [7:0]                            errorClass,
    input  wire logic [ADDR_W-1:0]                     s_axi_awaddr,
    input  wire logic                                  s_axi_awvalid,
    output logic                                       s_axi_awready,
    input  wire logic [31:0]                           s_axi_wdata,
    input  wire logic [3:0]                            s_axi_wstrb,
    input  wire logic                                  s_axi_wvalid,
    output logic                                       s_axi_wready,
    output logic [1:0]                                 s_axi_bresp,
    output logic                                       s_axi_bvalid,
    input  wire logic                                  s_axi_bready,
    input  wire logic [ADDR_W-1:0]                     s_axi_araddr,
    input  wire logic                                  s_axi_arvalid,
    output logic                                       s_axi_arready,
    output logic [31:0]                                s_axi_rdata,
    output logic [1:0]                                 s_axi_rresp,
    output logic                                       s_axi_rvalid,
    input  wire logic                                  s_axi_rready
);

    localparam int IDX_W = ADDR_W - 2;
    localparam int SLOTS = 7;

    // ----------------------------------------
    // Record building
    // ----------------------------------------
    error_history_stack_pkg::record_t slotMem [1:SLOTS];
    error_history_stack_pkg::record_t newRecord;
    logic [15:0]                      stdCode;
    wire logic                        isVoltage;
    wire logic                        isCurrent;
    wire logic                        isTemp;

    assign isVoltage = (faultIn.number == error_history_stack_pkg::FAULT_SUPPLY_INPUT_VOLTAGE_HIGH)
                    || (faultIn.number == error_history_stack_pkg::FAULT_SUPPLY_INPUT_VOLTAGE_LOW);
    assign isCurrent = faultIn.number == error_history_stack_pkg::FAULT_OUTPUT_CURRENT_HIGH;
    assign isTemp    = faultIn.number == error_history_stack_pkg::FAULT_OVERTEMPERATURE;

    // Unlisted causes fall back to the general code
    assign stdCode = isCurrent ? `CODE_CURRENT :
                     isVoltage ? `CODE_VOLTAGE :
                     isTemp    ? `CODE_TEMPERATURE : `CODE_GENERAL;

    assign newRecord.number   = faultIn.number;
    assign newRecord.errClass = errorClass;
    assign newRecord.code     = stdCode;

    // ----------------------------------------
    // History shift
    // ----------------------------------------
    for (genvar k = 1; k <= SLOTS; k++) begin : gSlot
        if (k == 1) begin : gNewest
            always_ff @(posedge clk) begin
                if (sys_rst) begin
                    slotMem[k] <= `RESET_ENTRY;
                end else if (faultIn.valid) begin
                    slotMem[k] <= newRecord;
                end
            end
        end else begin : gOlder
            // Slot seven is overwritten, so its old record drops out
            always_ff @(posedge clk) begin
                if (sys_rst) begin
                    slotMem[k] <= `RESET_ENTRY;
                end else if (faultIn.valid) begin
                    slotMem[k] <= slotMem[k-1];
                end
            end

            chk_shift_back: assert property (
                @(posedge clk) disable iff (sys_rst)
                faultIn.valid |=> slotMem[k] == $past(slotMem[k-1])
            ) else $error("history slot did not shift back");
        end
    end

    // ----------------------------------------
    // Write channel
    // ----------------------------------------
    logic             awHeld;
    logic             wHeld;
    logic [IDX_W-1:0] wrIndex;
    logic [31:0]      wrData;
    logic [3:0]       wrStrb;
    logic [1:0]       next_bresp;
    wire logic        wrCommit;
    wire logic [31:0] strbMask;
    wire logic        wrZero;
    wire logic        wrIsCount;
    wire logic        wrIsEntry;
    wire logic        countClear;

    assign s_axi_awready = !awHeld;
    assign s_axi_wready  = !wHeld;
    assign wrCommit      = awHeld && wHeld && !s_axi_bvalid;
    assign strbMask      = {{8{wrStrb[3]}}, {8{wrStrb[2]}}, {8{wrStrb[1]}}, {8{wrStrb[0]}}};
    assign wrZero        = (wrData & strbMask) == 32'h0000_0000;
    assign wrIsCount     = wrIndex == IDX_W'(`IDX_COUNT);
    assign wrIsEntry     = (wrIndex >= IDX_W'(`IDX_FIRST)) && (wrIndex <= IDX_W'(`IDX_LAST));
    assign countClear    = wrCommit && wrIsCount && wrZero;

    // Nonzero count writes and all entry writes are refused
    assign next_bresp = (wrIsCount && wrZero) ? `RESP_OKAY :
                        (wrIsCount || wrIsEntry) ? `RESP_SLVERR : `RESP_DECERR;

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            awHeld  <= 1'b0;
            wrIndex <= '0;
        end else if (s_axi_awvalid && s_axi_awready) begin
            awHeld  <= 1'b1;
            wrIndex <= s_axi_awaddr[ADDR_W-1:2];
        end else if (wrCommit) begin
            awHeld  <= 1'b0;
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            wHeld  <= 1'b0;
            wrData <= 32'h0000_0000;
            wrStrb <= 4'h0;
        end else if (s_axi_wvalid && s_axi_wready) begin
            wHeld  <= 1'b1;
            wrData <= s_axi_wdata;
            wrStrb <= s_axi_wstrb;
        end else if (wrCommit) begin
            wHeld  <= 1'b0;
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp  <= `RESP_OKAY;
        end else if (wrCommit) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= next_bresp;
        end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
        end
    end

    // ----------------------------------------
    // Fault count
    // ----------------------------------------
    logic [3:0]       logCount;
    wire logic [3:0]  countBase;
    wire logic [3:0]  next_count;

    // A clear and a fault in one cycle leave a count of one
    assign countBase  = countClear ? `RESET_COUNT : logCount;
    assign next_count = (faultIn.valid && countBase < `SHIFT_DEPTH)
                      ? countBase + 4'h1 : countBase;

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            logCount <= `RESET_COUNT;
        end else begin
            logCount <= next_count;
        end
    end

    // ----------------------------------------
    // Read channel
    // ----------------------------------------
    wire logic [IDX_W-1:0] rdIndex;
    wire logic             rdIsCount;
    wire logic             rdIsEntry;
    wire logic             rdStored;
    wire logic [31:0]      entryValue;
    wire logic [31:0]      next_rdata;
    wire logic [1:0]       next_rresp;

    assign s_axi_arready = !s_axi_rvalid;
    assign rdIndex   = s_axi_araddr[ADDR_W-1:2];
    assign rdIsCount = rdIndex == IDX_W'(`IDX_COUNT);
    assign rdIsEntry = (rdIndex >= IDX_W'(`IDX_FIRST)) && (rdIndex <= IDX_W'(`IDX_LAST));
    assign rdStored  = rdIsEntry && (rdIndex <= IDX_W'(`SHIFT_DEPTH));

    // Slot eight never receives a record and keeps its preset
    assign entryValue = rdStored ? slotMem[rdIndex] : `RESET_ENTRY;

    assign next_rdata = rdIsCount ? {28'h000_0000, logCount} :
                        !rdIsEntry ? 32'h0000_0000 :
                        (logCount == `RESET_COUNT) ? `ABORT_EMPTY : entryValue;
    assign next_rresp = rdIsCount ? `RESP_OKAY :
                        !rdIsEntry ? `RESP_DECERR :
                        (logCount == `RESET_COUNT) ? `RESP_SLVERR : `RESP_OKAY;

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata  <= 32'h0000_0000;
            s_axi_rresp  <= `RESP_OKAY;
        end else if (s_axi_arvalid && s_axi_arready) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata  <= next_rdata;
            s_axi_rresp  <= next_rresp;
        end else if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end
    end

    // ----------------------------------------
    // Checks
    // ----------------------------------------
    chk_push_newest: assert property (
        @(posedge clk) disable iff (sys_rst)
        faultIn.valid |=> slotMem[1] == $past(newRecord)
    ) else $error("new fault not placed in the newest slot");

    chk_oldest_drop: assert property (
        @(posedge clk) disable iff (sys_rst)
        faultIn.valid ##1 faultIn.valid |=> slotMem[SLOTS] == $past(slotMem[SLOTS-2], 2)
    ) else $error("oldest record was not discarded");

    chk_count_step: assert property (
        @(posedge clk) disable iff (sys_rst)
        faultIn.valid && !countClear && logCount < `SHIFT_DEPTH
        |=> logCount == $past(logCount) + 4'h1
    ) else $error("fault count did not advance by one");

    chk_count_cap: assert property (
        @(posedge clk) disable iff (sys_rst)
        logCount == `SHIFT_DEPTH && !countClear |=> logCount == `SHIFT_DEPTH
    ) else $error("fault count left its ceiling");

    chk_empty_abort: assert property (
        @(posedge clk) disable iff (sys_rst)
        s_axi_arvalid && s_axi_arready && rdIsEntry && logCount == `RESET_COUNT
        |=> s_axi_rvalid && s_axi_rresp == `RESP_SLVERR && s_axi_rdata == `ABORT_EMPTY
    ) else $error("empty history read not refused with abort code");

    chk_zero_restart: assert property (
        @(posedge clk) disable iff (sys_rst)
        countClear && !faultIn.valid |=> logCount == `RESET_COUNT
    ) else $error("zero write did not restart the count");

    chk_entry_readonly: assert property (
        @(posedge clk) disable iff (sys_rst)
        wrCommit && wrIsEntry && !faultIn.valid
        |=> s_axi_bvalid && s_axi_bresp == `RESP_SLVERR && slotMem[1] == $past(slotMem[1])
    ) else $error("write to a history slot was not refused");

    chk_code_current: assert property (
        @(posedge clk) disable iff (sys_rst)
        faultIn.valid && faultIn.number == 8'h02 |=> slotMem[1].code == `CODE_CURRENT
    ) else $error("output current fault got the wrong code");

    chk_code_voltage: assert property (
        @(posedge clk) disable iff (sys_rst)
        faultIn.valid && (faultIn.number == 8'h01 || faultIn.number == 8'h03)
        |=> slotMem[1].code == `CODE_VOLTAGE && slotMem[1].number == $past(faultIn.number)
    ) else $error("supply fault stored wrongly");

    chk_class_copy: assert property (
        @(posedge clk) disable iff (sys_rst)
        faultIn.valid |=> slotMem[1].errClass == $past(errorClass)
    ) else $error("class byte differs from the error register");

    chk_read_answer: assert property (
        @(posedge clk) disable iff (sys_rst)
        s_axi_arvalid && s_axi_arready && rdIsCount
        |=> s_axi_rvalid && s_axi_rdata == {28'h000_0000, $past(logCount)}
    ) else $error("count read answered late or wrongly");

    chk_write_answer: assert property (
        @(posedge clk) disable iff (sys_rst)
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready && !s_axi_bvalid
        |=> ##1 s_axi_bvalid
    ) else $error("write response not given two cycles after the request");

    chk_code_temp: assert property (
        @(posedge clk) disable iff (sys_rst)
        faultIn.valid && faultIn.number == 8'h0C |=> slotMem[1].code == `CODE_TEMPERATURE
    ) else $error("overtemperature fault got the wrong code");

    chk_code_general: assert property (
        @(posedge clk) disable iff (sys_rst)
        faultIn.valid && faultIn.number != 8'h01 && faultIn.number != 8'h02
        && faultIn.number != 8'h03 && faultIn.number != 8'h0C
        |=> slotMem[1].code == `CODE_GENERAL
    ) else $error("unlisted fault did not get the general code");

    chk_number_kept: assert property (
        @(posedge clk) disable iff (sys_rst)
        faultIn.valid |=> slotMem[1].number == $past(faultIn.number)
    ) else $error("fault number not stored unchanged");

    chk_slot_preset: assert property (
        @(posedge clk)
        sys_rst |=> slotMem[1] == `RESET_ENTRY && slotMem[SLOTS] == `RESET_ENTRY
                    && logCount == `RESET_COUNT
    ) else $error("history not back at its preset after reset");

    chk_slot_eight: assert property (
        @(posedge clk) disable iff (sys_rst)
        s_axi_arvalid && s_axi_arready && rdIndex == IDX_W'(`IDX_LAST) && logCount != `RESET_COUNT
        |=> s_axi_rvalid && s_axi_rdata == `RESET_ENTRY && s_axi_rresp == `RESP_OKAY
    ) else $error("slot eight did not read its preset");

    chk_count_hold: assert property (
        @(posedge clk) disable iff (sys_rst)
        !faultIn.valid && !countClear |=> logCount == $past(logCount)
    ) else $error("fault count moved without a fault");

    chk_nonzero_ignored: assert property (
        @(posedge clk) disable iff (sys_rst)
        wrCommit && wrIsCount && !wrZero && !faultIn.valid
        |=> s_axi_bvalid && s_axi_bresp == `RESP_SLVERR && logCount == $past(logCount)
    ) else $error("nonzero count write was not refused");

    chk_history_frozen: assert property (
        @(posedge clk) disable iff (sys_rst)
        !faultIn.valid
        |=> slotMem[1] == $past(slotMem[1]) && slotMem[SLOTS] == $past(slotMem[SLOTS])
    ) else $error("history moved without a fault");

endmodule // error_history_stack

`default_nettype wire

// ---- error_history_stack_params.svh ----
`ifndef ERROR_HISTORY_STACK_PARAMS_SVH
`define ERROR_HISTORY_STACK_PARAMS_SVH

// ----------------------------------------
// Register indexes (byte address = 4 * index)
// ----------------------------------------
`define IDX_COUNT               4'h0
`define IDX_FIRST               4'h1
`define IDX_ERROR_HISTORY_ENTRY_4 4'h4
`define IDX_ERROR_HISTORY_ENTRY_5 4'h5
`define IDX_ERROR_HISTORY_ENTRY_7 4'h7
`define IDX_ERROR_HISTORY_ENTRY_8 4'h8
`define IDX_LAST                4'h8

// ----------------------------------------
// Stack geometry and values
// ----------------------------------------
`define SHIFT_DEPTH             4'h7
`define RESET_ENTRY             32'h0000_0000
`define RESET_COUNT             4'h0
`define ABORT_EMPTY             32'h0800_0024

// ----------------------------------------
// Standard error codes
// ----------------------------------------
`define CODE_GENERAL            16'h1000
`define CODE_CURRENT            16'h2300
`define CODE_VOLTAGE            16'h3100
`define CODE_TEMPERATURE        16'h4200

// ----------------------------------------
// AXI responses
// ----------------------------------------
`define RESP_OKAY               2'h0
`define RESP_SLVERR             2'h2
`define RESP_DECERR             2'h3

`endif

// ---- error_history_stack_pkg.sv ----
`default_nettype none

package error_history_stack_pkg;

    // ----------------------------------------
    // Fault numbers
    // ----------------------------------------
    typedef enum logic [7:0] {
        FAULT_WATCHDOG_RESET             = 8'h00,
        FAULT_SUPPLY_INPUT_VOLTAGE_HIGH  = 8'h01,
        FAULT_OUTPUT_CURRENT_HIGH        = 8'h02,
        FAULT_SUPPLY_INPUT_VOLTAGE_LOW   = 8'h03,
        FAULT_FIELDBUS                   = 8'h04,
        FAULT_OVERTEMPERATURE            = 8'h0C
    } fault_num_t;

    // ----------------------------------------
    // Stored record, number in the top byte
    // ----------------------------------------
    typedef struct packed {
        logic [7:0]  number;
        logic [7:0]  errClass;
        logic [15:0] code;
    } record_t;

    // ----------------------------------------
    // Report from the fault detectors
    // ----------------------------------------
    typedef struct packed {
        logic        valid;
        logic [7:0]  number;
    } fault_report_t;

endpackage

`default_nettype wire

// ---- error_history_stack_test.sv ----
`timescale 1ns/1ns
`default_nettype none
`include "error_history_stack_params.svh"

module error_history_stack_test;
    logic                                   clk;
    logic                                   sys_rst;
    error_history_stack_pkg::fault_report_t faultIn;
    logic [7:0]                             errorClass;
    logic [5:0]                             s_axi_awaddr;
    logic                                   s_axi_awvalid;
    logic                                   s_axi_awready;
    logic [31:0]                            s_axi_wdata;
    logic                                   s_axi_wvalid;
    logic                                   s_axi_wready;
    logic [1:0]                             s_axi_bresp;
    logic                                   s_axi_bvalid;
    logic [5:0]                             s_axi_araddr;
    logic                                   s_axi_arvalid;
    logic                                   s_axi_arready;
    logic [31:0]                            s_axi_rdata;
    logic [1:0]                             s_axi_rresp;
    logic                                   s_axi_rvalid;
    int                                     mismatches = 0;
    int                                     nCompared = 0;
    // Rows: fault number, class byte, expected code
    error_history_stack_pkg::record_t       rows [7] = '{32'h0081_1000, 32'h0105_3100,
        32'h0203_2300, 32'h0305_3100, 32'h0411_1000, 32'h0C09_4200, 32'h2B05_1000};

    error_history_stack uut (.clk(clk), .sys_rst(sys_rst), .faultIn(faultIn),
        .errorClass(errorClass), .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
        .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(4'hF),
        .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
        .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(1'h1), .s_axi_araddr(s_axi_araddr),
        .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
        .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
        .s_axi_rready(1'h1));

    // ----------------------------------------
    // Checking and bus tasks
    // ----------------------------------------
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        nCompared++;
        if (seen !== exp) begin
            mismatches++;
            $display("wrong value %s: expected %h, seen %h", what, exp, seen);
        end
    endtask

    task test_done;
        $display("compared %0d, mismatches %0d", nCompared, mismatches);
        if (mismatches == 0 && nCompared > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask

    // Ready lines are held high, so only valid needs releasing
    task automatic readCheck(input logic [3:0] idx, input logic [31:0] expData,
                             input logic [1:0] expResp);
        s_axi_araddr  <= {idx, 2'h0};
        s_axi_arvalid <= 1'h1;
        do @(posedge clk); while (s_axi_arready !== 1'h1);
        s_axi_arvalid <= 1'h0;
        do @(posedge clk); while (s_axi_rvalid !== 1'h1);
        check($sformatf("read data %0d", idx), s_axi_rdata, expData);
        check($sformatf("read resp %0d", idx), {30'h0, s_axi_rresp}, {30'h0, expResp});
    endtask

    task automatic writeCheck(input logic [3:0] idx, input logic [31:0] data,
                              input logic [1:0] expResp);
        logic awTaken;
        logic wTaken;
        awTaken = 1'h0;
        wTaken  = 1'h0;
        s_axi_awaddr  <= {idx, 2'h0};
        s_axi_wdata   <= data;
        s_axi_awvalid <= 1'h1;
        s_axi_wvalid  <= 1'h1;
        while (!(awTaken && wTaken)) begin
            @(posedge clk);
            if (!awTaken && s_axi_awready === 1'h1) begin
                awTaken = 1'h1;
                s_axi_awvalid <= 1'h0;
            end
            if (!wTaken && s_axi_wready === 1'h1) begin
                wTaken = 1'h1;
                s_axi_wvalid <= 1'h0;
            end
        end
        do @(posedge clk); while (s_axi_bvalid !== 1'h1);
        check($sformatf("write resp %0d", idx), {30'h0, s_axi_bresp}, {30'h0, expResp});
    endtask

    // Leaves valid high so two calls give back-to-back faults
    task automatic pushFault(input error_history_stack_pkg::record_t rec);
        faultIn    <= '{valid: 1'h1, number: rec.number};
        errorClass <= rec.errClass;
        @(posedge clk);
    endtask

    // ----------------------------------------
    // Clock, watchdog and main sequence
    // ----------------------------------------
    initial begin
        clk = 1'h0;
        forever #10 clk = ~clk;
    end

    initial begin
        repeat (5000) @(posedge clk);
        mismatches++;
        test_done;
    end

    initial begin
        sys_rst = 1'h1;
        faultIn = '0;
        errorClass = 8'h00;
        s_axi_awaddr = 6'h00;
        s_axi_awvalid = 1'h0;
        s_axi_wdata = 32'h0000_0000;
        s_axi_wvalid = 1'h0;
        s_axi_araddr = 6'h00;
        s_axi_arvalid = 1'h0;
        repeat (8) @(posedge clk);
        sys_rst <= 1'h0;
        readCheck(4'h0, 32'h0000_0000, `RESP_OKAY);
        for (int i = 1; i <= 8; i++)
            readCheck(4'(i), `ABORT_EMPTY, `RESP_SLVERR);
        for (int i = 0; i < 7; i++) begin
            pushFault(rows[i]);
            faultIn.valid <= 1'h0;
            readCheck(4'h0, 32'(i + 1), `RESP_OKAY);
            readCheck(4'h1, rows[i], `RESP_OKAY);
        end
        for (int k = 1; k <= 7; k++)
            readCheck(4'(k), rows[7 - k], `RESP_OKAY);
        readCheck(4'h8, `RESET_ENTRY, `RESP_OKAY);
        // Two faults on consecutive edges push out two old records
        pushFault(32'h0D22_1000);
        pushFault(32'h0244_2300);
        faultIn.valid <= 1'h0;
        readCheck(4'h0, 32'h0000_0007, `RESP_OKAY);
        readCheck(4'h1, 32'h0244_2300, `RESP_OKAY);
        readCheck(4'h2, 32'h0D22_1000, `RESP_OKAY);
        readCheck(4'h3, rows[6], `RESP_OKAY);
        readCheck(4'h7, rows[2], `RESP_OKAY);
        writeCheck(4'h1, 32'hFFFF_FFFF, `RESP_SLVERR);
        readCheck(4'h1, 32'h0244_2300, `RESP_OKAY);
        writeCheck(4'h9, 32'h0000_0000, `RESP_DECERR);
        readCheck(4'hF, 32'h0000_0000, `RESP_DECERR);
        writeCheck(4'h0, 32'h0000_0005, `RESP_SLVERR);
        readCheck(4'h0, 32'h0000_0007, `RESP_OKAY);
        writeCheck(4'h0, 32'h0000_0000, `RESP_OKAY);
        readCheck(4'h0, 32'h0000_0000, `RESP_OKAY);
        readCheck(4'h3, `ABORT_EMPTY, `RESP_SLVERR);
        pushFault(32'h0481_1000);
        faultIn.valid <= 1'h0;
        readCheck(4'h0, 32'h0000_0001, `RESP_OKAY);
        readCheck(4'h1, 32'h0481_1000, `RESP_OKAY);
        // Second reset in mid-run clears records back to preset
        sys_rst <= 1'h1;
        repeat (2) @(posedge clk);
        sys_rst <= 1'h0;
        readCheck(4'h0, `RESET_ENTRY, `RESP_OKAY);
        readCheck(4'h8, `ABORT_EMPTY, `RESP_SLVERR);
        pushFault(32'h0303_3100);
        faultIn.valid <= 1'h0;
        readCheck(4'h4, `RESET_ENTRY, `RESP_OKAY);
        readCheck(4'h1, 32'h0303_3100, `RESP_OKAY);
        test_done;
    end
endmodule // error_history_stack_test

`default_nettype wire
